/* File: taix_chk.sv */
// assertions on the instruction port of the timer-access block
`timescale 1ns/1ps
module taix_chk
	import taix_pkg::*;
(
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic INSTR_VALID,
	input wire logic [TAIX_OPW-1:0] INSTR_CODE,
	input wire logic [TAIX_NIB-1:0] ACC_IN,
	input wire logic [TAIX_NIB-1:0] UPPER_IN,
	input wire logic [TAIX_CNTW-1:0] TIMER1_COUNT,
	input wire logic [TAIX_CNTW-1:0] TIMER2_COUNT,
	input wire logic [TAIX_CNTW-1:0] TIMER3_COUNT,
	input wire logic [TAIX_CNTW-1:0] TIMER4_COUNT,
	input wire logic [TAIX_TIMERS-1:0] TIMER_EVENT,
	input wire logic ACC_LOAD,
	input wire logic [TAIX_NIB-1:0] ACC_OUT,
	input wire logic UPPER_LOAD,
	input wire logic [TAIX_NIB-1:0] UPPER_OUT,
	input wire logic [TAIX_TIMERS-1:0] TIMER_LOAD,
	input wire logic [TAIX_TIMERS-1:0] RELOAD_LOAD,
	input wire logic [TAIX_CNTW-1:0] LOAD_VALUE,
	input wire logic SKIP_NEXT,
	input wire logic [TAIX_TIMERS-1:0] EVENT_FLAG,
	input wire logic [7:0] AVS_ADDRESS,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	input wire logic AVS_WAITREQUEST
);
	// ----------------------------------------
	// decode helpers
	// ----------------------------------------
	logic rd, wr, sk, hit, en_m, rl1, rl3;
	logic [3:0] sel1, clr, setm;
	logic [7:0] cnt, ba;
	// enable tracked from the bus, so disabled opcodes expect nothing
	always_ff @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
			en_m <= TAIX_CTRL_EN_RESET;
		else if (AVS_WRITE && !AVS_WAITREQUEST &&
			AVS_ADDRESS == TAIX_REG_CTRL && AVS_BYTEENABLE[0])
			en_m <= AVS_WRITEDATA[TAIX_CTRL_EN_BIT];
	end
	assign rd = INSTR_VALID && en_m && INSTR_CODE[9:2] == 8'h9C;
	assign wr = INSTR_VALID && en_m && INSTR_CODE[9:2] == 8'h8C;
	assign sk = INSTR_VALID && en_m && INSTR_CODE[9:2] == 8'hA0;
	assign rl1 = INSTR_VALID && en_m && INSTR_CODE == 10'h23F;
	assign rl3 = INSTR_VALID && en_m && INSTR_CODE == 10'h23B;
	assign ba = {UPPER_IN, ACC_IN};
	assign sel1 = 4'h1 << INSTR_CODE[1:0];
	assign hit = |(EVENT_FLAG & sel1);
	assign clr = (sk && hit) ? sel1 : 4'h0;
	assign setm = TIMER_EVENT & ~clr;
	assign cnt = INSTR_CODE[1] ? (INSTR_CODE[0] ? TIMER4_COUNT : TIMER3_COUNT)
		: (INSTR_CODE[0] ? TIMER2_COUNT : TIMER1_COUNT);
	default clocking @(posedge MCLK);
	endclocking
	default disable iff (!RST_N);
	// ----------------------------------------
	// properties
	// ----------------------------------------
	a_read_nibbles:
	assert property (rd |=> ACC_LOAD && UPPER_LOAD
		&& {UPPER_OUT, ACC_OUT} == $past(cnt)) else $error("bad read");
	a_read_cause:
	assert property (ACC_LOAD |-> $past(rd)) else $error("stray read");
	a_write_pair:
	assert property (wr |=> TIMER_LOAD == RELOAD_LOAD
		&& TIMER_LOAD == $past(sel1)
		&& LOAD_VALUE == $past(ba)) else $error("bad write");
	a_write_cause:
	assert property (|TIMER_LOAD |-> $past(wr)) else $error("stray load");
	a_reload_one:
	assert property (rl1 |=>
		RELOAD_LOAD == 4'h1 && TIMER_LOAD == 4'h0
		&& LOAD_VALUE == $past(ba)) else $error("bad rl1");
	a_reload_three:
	assert property (rl3 |=>
		RELOAD_LOAD == 4'h4 && TIMER_LOAD == 4'h0) else $error("bad rl3");
	a_skip_taken:
	assert property (sk && hit |=> SKIP_NEXT
		&& (EVENT_FLAG & $past(sel1)) == 4'h0) else $error("no skip");
	a_skip_kept:
	assert property (sk && !hit |=> !SKIP_NEXT && (EVENT_FLAG & $past(sel1))
		== ($past(TIMER_EVENT) & $past(sel1))) else $error("false skip");
	a_flag_set:
	assert property (|TIMER_EVENT |=> (EVENT_FLAG & $past(setm))
		== $past(setm)) else $error("flag not set");
	a_flag_hold:
	assert property (1'h1 |=> ($past(EVENT_FLAG) & ~EVENT_FLAG
		& ~$past(clr)) == 4'h0) else $error("flag lost");
	c_read: cover property (rd ##1 ACC_LOAD);
	c_skip: cover property (SKIP_NEXT);
	c_reload: cover property (|RELOAD_LOAD && TIMER_LOAD == 4'h0);
endmodule : taix_chk

bind taix_top taix_chk chk (
	.MCLK(MCLK), .RST_N(RST_N), .INSTR_VALID(INSTR_VALID),
	.INSTR_CODE(INSTR_CODE), .ACC_IN(ACC_IN), .UPPER_IN(UPPER_IN),
	.TIMER1_COUNT(TIMER1_COUNT), .TIMER2_COUNT(TIMER2_COUNT),
	.TIMER3_COUNT(TIMER3_COUNT), .TIMER4_COUNT(TIMER4_COUNT),
	.TIMER_EVENT(TIMER_EVENT), .ACC_LOAD(ACC_LOAD), .ACC_OUT(ACC_OUT),
	.UPPER_LOAD(UPPER_LOAD), .UPPER_OUT(UPPER_OUT), .TIMER_LOAD(TIMER_LOAD),
	.RELOAD_LOAD(RELOAD_LOAD), .LOAD_VALUE(LOAD_VALUE),
	.SKIP_NEXT(SKIP_NEXT), .EVENT_FLAG(EVENT_FLAG),
	.AVS_ADDRESS(AVS_ADDRESS), .AVS_WRITE(AVS_WRITE),
	.AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
	.AVS_WAITREQUEST(AVS_WAITREQUEST)
);

/* File: taix_decode.sv */
// opcode classifier for the timer-access group
`timescale 1ns/1ps
module taix_decode
	import taix_pkg::*;
(
	input wire logic [TAIX_OPW-1:0] opcode,
	output taix_op_t op,
	output logic [TAIX_SELW-1:0] sel
);

	// ----------------------------------------------------------------
	// classification
	// ----------------------------------------------------------------
	always_comb
	begin
		op = TAIX_OP_NONE;
		sel = opcode[TAIX_SELW-1:0];
		if ((opcode & TAIX_SEL_MASK) == TAIX_OP_READ_BASE)
		begin
			op = TAIX_OP_READ; // RULE_02
		end
		else if ((opcode & TAIX_SEL_MASK) == TAIX_OP_WRITE_BASE)
		begin
			op = TAIX_OP_WRITE; // RULE_04
		end
		else if (opcode == TAIX_OP_RELOAD_ONE)
		begin
			op = TAIX_OP_RELOAD; // RULE_05
			sel = TAIX_SEL_ONE;
		end
		else if (opcode == TAIX_OP_RELOAD_THREE)
		begin
			op = TAIX_OP_RELOAD; // RULE_06
			sel = TAIX_SEL_THREE;
		end
		else if ((opcode & TAIX_SEL_MASK) == TAIX_OP_SKIP_BASE)
		begin
			op = TAIX_OP_SKIP; // RULE_09
		end
	end

endmodule : taix_decode

/* File: taix_flags.sv */
// per-timer event flags, set by the timer, cleared by a taken skip
`timescale 1ns/1ps
module taix_flags
	import taix_pkg::*;
#(
	parameter int N = TAIX_TIMERS
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [N-1:0] set,
	input wire logic [N-1:0] clr,
	output logic [N-1:0] flag_q
);

	// ----------------------------------------------------------------
	// flag bits
	// ----------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < N; i++)
		begin : g_flag
			// clear beats a same-cycle set, else the skip would repeat
			always_ff @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
					flag_q[i] <= 1'b0;
				else if (clr[i])
					flag_q[i] <= 1'b0; // RULE_10
				else if (set[i])
					flag_q[i] <= 1'b1; // RULE_10
			end
		end
	endgenerate

endmodule : taix_flags

/* File: taix_pkg.sv */
// constants and types shared by the timer-access instruction logic
package taix_pkg;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int TAIX_TIMERS = 4;
	localparam int TAIX_OPW = 10;
	localparam int TAIX_NIB = 4;
	localparam int TAIX_CNTW = 8;
	localparam int TAIX_SELW = 2;
	localparam int TAIX_EXECW = 16;
	localparam int TAIX_IRQW = 5;

	// ----------------------------------------------------------------
	// opcodes of the group
	// ----------------------------------------------------------------
	localparam logic [9:0] TAIX_SEL_MASK = 10'h3FC;
	localparam logic [9:0] TAIX_OP_READ_BASE = 10'h270;
	localparam logic [9:0] TAIX_OP_WRITE_BASE = 10'h230;
	localparam logic [9:0] TAIX_OP_RELOAD_ONE = 10'h23F;
	localparam logic [9:0] TAIX_OP_RELOAD_THREE = 10'h23B;
	localparam logic [9:0] TAIX_OP_SKIP_BASE = 10'h280;
	localparam logic [1:0] TAIX_SEL_ONE = 2'h0;
	localparam logic [1:0] TAIX_SEL_THREE = 2'h2;

	typedef enum logic [2:0]
	{
		TAIX_OP_NONE = 3'h0,
		TAIX_OP_READ = 3'h1,
		TAIX_OP_WRITE = 3'h3,
		TAIX_OP_RELOAD = 3'h2,
		TAIX_OP_SKIP = 3'h6
	} taix_op_t;

	// ----------------------------------------------------------------
	// register map (byte addresses, one word each)
	// ----------------------------------------------------------------
	localparam logic [7:0] TAIX_REG_CTRL = 8'h00;
	localparam logic [7:0] TAIX_REG_STATUS = 8'h04;
	localparam logic [7:0] TAIX_REG_IRQ_STAT = 8'h08;
	localparam logic [7:0] TAIX_REG_IRQ_MASK = 8'h0C;
	localparam logic [7:0] TAIX_REG_EXEC_CNT = 8'h10;

	localparam int TAIX_CTRL_EN_BIT = 0;
	localparam logic TAIX_CTRL_EN_RESET = 1'b1;
	localparam int TAIX_STAT_FLAG_LSB = 0;
	localparam int TAIX_STAT_OP_LSB = 8;
	localparam int TAIX_IRQ_FLAG_LSB = 0;
	localparam int TAIX_IRQ_SKIP_BIT = 4;
	localparam logic [4:0] TAIX_IRQ_MASK_RESET = 5'h00;
	localparam logic [9:0] TAIX_LAST_OP_RESET = 10'h000;

endpackage : taix_pkg

/* File: taix_seq.sv */
// cpu sequencer model: issues opcodes, keeps A and B, honours skips
`timescale 1ns/1ps
module taix_seq
	import taix_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic skip,
	input wire logic a_ld,
	input wire logic [TAIX_NIB-1:0] a_in,
	input wire logic b_ld,
	input wire logic [TAIX_NIB-1:0] b_in,
	output logic valid,
	output logic [TAIX_OPW-1:0] code,
	output logic [TAIX_NIB-1:0] acc_q,
	output logic [TAIX_NIB-1:0] upper_q
);
	logic [TAIX_OPW-1:0] prog[$];
	int skipped;
	// idle slot after each issue, so a skip is seen before the next one
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			valid <= 1'h0;
			code <= 10'h000;
			acc_q <= 4'h0;
			upper_q <= 4'h0;
			skipped = 0;
		end
		else
		begin
			if (a_ld)
				acc_q <= a_in;
			if (b_ld)
				upper_q <= b_in;
			if (!valid && prog.size() > 0)
			begin
				code <= prog.pop_front();
				valid <= !skip;
				if (skip)
					skipped++;
			end
			else
			begin
				// idle slots carry junk codes that must be ignored
				valid <= 1'h0;
				code <= ~code;
			end
		end
	end
endmodule : taix_seq

/* File: taix_top.sv */
// timer-access instruction execution with avalon register slave
//
// Operation
// RULE_01: timer read loads B, A from count nibbles
// RULE_02: opcodes 270h-273h read timers one to four
// RULE_03: timer write loads count and reload from B,A
// RULE_04: opcodes 230h-233h write timer and reload
// RULE_05: 23Fh writes timer one reload only
// RULE_06: 23Bh writes timer three reload only
// RULE_07: 280h skips, clears timer one flag if set
// RULE_08: 281h same skip-and-clear for timer two flag
// RULE_09: 282h and 283h test timer three, four flags
// RULE_10: timer sets flags; skip clear wins that cycle
// RULE_11: sequencer skips following instruction on skip signal
//
// Our own choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
module taix_top
	import taix_pkg::*;
(
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic INSTR_VALID,
	input wire logic [TAIX_OPW-1:0] INSTR_CODE,
	input wire logic [TAIX_NIB-1:0] ACC_IN,
	input wire logic [TAIX_NIB-1:0] UPPER_IN,
	input wire logic [TAIX_CNTW-1:0] TIMER1_COUNT,
	input wire logic [TAIX_CNTW-1:0] TIMER2_COUNT,
	input wire logic [TAIX_CNTW-1:0] TIMER3_COUNT,
	input wire logic [TAIX_CNTW-1:0] TIMER4_COUNT,
	input wire logic [TAIX_TIMERS-1:0] TIMER_EVENT,
	output logic ACC_LOAD,
	output logic [TAIX_NIB-1:0] ACC_OUT,
	output logic UPPER_LOAD,
	output logic [TAIX_NIB-1:0] UPPER_OUT,
	output logic [TAIX_TIMERS-1:0] TIMER_LOAD,
	output logic [TAIX_TIMERS-1:0] RELOAD_LOAD,
	output logic [TAIX_CNTW-1:0] LOAD_VALUE,
	output logic SKIP_NEXT,
	output logic [TAIX_TIMERS-1:0] EVENT_FLAG,
	output logic IRQ,
	input wire logic [7:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	taix_op_t dec_op;
	logic [TAIX_SELW-1:0] dec_sel;
	logic [TAIX_CNTW-1:0] count [TAIX_TIMERS];
	logic [TAIX_CNTW-1:0] sel_count;
	logic [TAIX_TIMERS-1:0] sel_onehot;
	logic [TAIX_TIMERS-1:0] flag_q;
	logic [TAIX_TIMERS-1:0] flag_clr;
	logic exec;
	logic flag_hit;
	logic skip_take;

	logic en_q;
	logic [TAIX_OPW-1:0] last_op_q;
	logic [TAIX_EXECW-1:0] exec_cnt_q;
	logic [TAIX_IRQW-1:0] irq_stat_q;
	logic [TAIX_IRQW-1:0] irq_stat_d;
	logic [TAIX_IRQW-1:0] irq_mask_q;
	logic [TAIX_IRQW-1:0] irq_evt;
	logic [TAIX_IRQW-1:0] irq_w1c;
	logic irq_q;

	logic acc_load_q;
	logic [TAIX_NIB-1:0] acc_out_q;
	logic upper_load_q;
	logic [TAIX_NIB-1:0] upper_out_q;
	logic [TAIX_TIMERS-1:0] timer_load_q;
	logic [TAIX_TIMERS-1:0] reload_load_q;
	logic [TAIX_CNTW-1:0] load_value_q;
	logic skip_q;

	logic bus_req;
	logic bus_wr;
	logic wait_q;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic [31:0] wmask;

	// ----------------------------------------------------------------
	// decode and operand selection
	// ----------------------------------------------------------------
	taix_decode u_decode
	(
		.opcode(INSTR_CODE),
		.op(dec_op),
		.sel(dec_sel)
	);

	assign count[0] = TIMER1_COUNT;
	assign count[1] = TIMER2_COUNT;
	assign count[2] = TIMER3_COUNT;
	assign count[3] = TIMER4_COUNT;

	// an instruction of another group, or one while disabled, is ignored
	assign exec = INSTR_VALID && en_q && (dec_op != TAIX_OP_NONE);
	assign sel_count = count[dec_sel];
	assign sel_onehot = TAIX_TIMERS'(1) << dec_sel;
	assign flag_hit = flag_q[dec_sel];
	assign skip_take = exec && (dec_op == TAIX_OP_SKIP) && flag_hit;

	// ----------------------------------------------------------------
	// event flags
	// ----------------------------------------------------------------
	// clear only on a taken skip; a clear flag is left alone
	assign flag_clr = skip_take ? sel_onehot : '0; // RULE_07 RULE_08

	taix_flags #(.N(TAIX_TIMERS)) u_flags
	(
		.clk(MCLK),
		.rst_n(RST_N),
		.set(TIMER_EVENT),
		.clr(flag_clr),
		.flag_q(flag_q)
	);

	// ----------------------------------------------------------------
	// working register results
	// ----------------------------------------------------------------
	always_ff @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			acc_load_q <= 1'b0;
			upper_load_q <= 1'b0;
			acc_out_q <= '0;
			upper_out_q <= '0;
		end
		else
		begin
			acc_load_q <= exec && (dec_op == TAIX_OP_READ); // RULE_01
			upper_load_q <= exec && (dec_op == TAIX_OP_READ); // RULE_01
			if (exec && (dec_op == TAIX_OP_READ))
			begin
				acc_out_q <= sel_count[TAIX_NIB-1:0]; // RULE_01
				upper_out_q <= sel_count[TAIX_CNTW-1:TAIX_NIB]; // RULE_01
			end
		end
	end

	// ----------------------------------------------------------------
	// timer and reload writes
	// ----------------------------------------------------------------
	always_ff @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			timer_load_q <= '0;
			reload_load_q <= '0;
			load_value_q <= '0;
		end
		else
		begin
			timer_load_q <= '0;
			reload_load_q <= '0;
			if (exec && (dec_op == TAIX_OP_WRITE))
			begin
				timer_load_q <= sel_onehot; // RULE_03
				reload_load_q <= sel_onehot; // RULE_03
			end
			else if (exec && (dec_op == TAIX_OP_RELOAD))
			begin
				// count untouched, only the reload strobe
				reload_load_q <= sel_onehot; // RULE_05 RULE_06
			end
			if (exec && ((dec_op == TAIX_OP_WRITE) ||
				(dec_op == TAIX_OP_RELOAD)))
			begin
				load_value_q <= {UPPER_IN, ACC_IN}; // RULE_03
			end
		end
	end

	// ----------------------------------------------------------------
	// skip request to the sequencer
	// ----------------------------------------------------------------
	// the sequencer turns the following word into a no-op
	always_ff @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
			skip_q <= 1'b0;
		else
			skip_q <= skip_take; // RULE_07 RULE_11
	end

	// ----------------------------------------------------------------
	// bookkeeping visible to software
	// ----------------------------------------------------------------
	always_ff @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			last_op_q <= TAIX_LAST_OP_RESET;
			exec_cnt_q <= '0;
		end
		else if (exec)
		begin
			last_op_q <= INSTR_CODE;
			exec_cnt_q <= exec_cnt_q + TAIX_EXECW'(1);
		end
	end

	// ----------------------------------------------------------------
	// avalon slave: one wait state per access
	// ----------------------------------------------------------------
	assign bus_req = AVS_READ || AVS_WRITE;
	// write lands on the edge that sees waitrequest low
	assign bus_wr = AVS_WRITE && !wait_q;

	generate
		genvar b;
		for (b = 0; b < 4; b++)
		begin : g_lane
			assign wmask[b*8 +: 8] = {8{AVS_BYTEENABLE[b]}};
		end
	endgenerate

	always_ff @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
			wait_q <= 1'b1;
		else if (bus_req && wait_q)
			wait_q <= 1'b0;
		else
			wait_q <= 1'b1;
	end

	always_comb
	begin
		rdata_d = '0;
		unique case (AVS_ADDRESS)
			TAIX_REG_CTRL:
				rdata_d[TAIX_CTRL_EN_BIT] = en_q;
			TAIX_REG_STATUS:
			begin
				rdata_d[TAIX_STAT_FLAG_LSB +: TAIX_TIMERS] = flag_q;
				rdata_d[TAIX_STAT_OP_LSB +: TAIX_OPW] = last_op_q;
			end
			TAIX_REG_IRQ_STAT:
				rdata_d[TAIX_IRQW-1:0] = irq_stat_q;
			TAIX_REG_IRQ_MASK:
				rdata_d[TAIX_IRQW-1:0] = irq_mask_q;
			TAIX_REG_EXEC_CNT:
				rdata_d[TAIX_EXECW-1:0] = exec_cnt_q;
			default:
				rdata_d = '0;
		endcase
	end

	always_ff @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
			rdata_q <= '0;
		else if (AVS_READ && wait_q)
			rdata_q <= rdata_d;
	end

	// ----------------------------------------------------------------
	// control and mask registers
	// ----------------------------------------------------------------
	always_ff @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
			en_q <= TAIX_CTRL_EN_RESET;
		else if (bus_wr && (AVS_ADDRESS == TAIX_REG_CTRL) &&
			AVS_BYTEENABLE[0])
			en_q <= AVS_WRITEDATA[TAIX_CTRL_EN_BIT];
	end

	always_ff @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
			irq_mask_q <= TAIX_IRQ_MASK_RESET;
		else if (bus_wr && (AVS_ADDRESS == TAIX_REG_IRQ_MASK) &&
			AVS_BYTEENABLE[0])
			irq_mask_q <= AVS_WRITEDATA[TAIX_IRQW-1:0];
	end

	// ----------------------------------------------------------------
	// interrupt status
	// ----------------------------------------------------------------
	assign irq_evt = {skip_take, TIMER_EVENT};
	assign irq_w1c = (bus_wr && (AVS_ADDRESS == TAIX_REG_IRQ_STAT)) ?
		(AVS_WRITEDATA[TAIX_IRQW-1:0] & wmask[TAIX_IRQW-1:0]) : '0;
	// a new event in the clearing cycle survives the clear
	assign irq_stat_d = (irq_stat_q & ~irq_w1c) | irq_evt;

	always_ff @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
			irq_stat_q <= '0;
		else
			irq_stat_q <= irq_stat_d;
	end

	// registered, so it trails the status bit by one clock
	always_ff @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
			irq_q <= 1'b0;
		else
			irq_q <= |(irq_stat_q & irq_mask_q);
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign ACC_LOAD = acc_load_q;
	assign ACC_OUT = acc_out_q;
	assign UPPER_LOAD = upper_load_q;
	assign UPPER_OUT = upper_out_q;
	assign TIMER_LOAD = timer_load_q;
	assign RELOAD_LOAD = reload_load_q;
	assign LOAD_VALUE = load_value_q;
	assign SKIP_NEXT = skip_q;
	assign EVENT_FLAG = flag_q;
	assign IRQ = irq_q;
	assign AVS_READDATA = rdata_q;
	assign AVS_WAITREQUEST = wait_q;

endmodule : taix_top

/* File: testbench.sv */
// self-checking bench for the timer-access instruction block
`timescale 1ns/1ps
module testbench
	import taix_pkg::*;
;
	logic mclk = 1'h0;
	logic rst_n = 1'h0;
	logic vld, a_ld, b_ld, skip, irq, rd, wr, wq;
	logic [9:0] code;
	logic [3:0] acc, upper, a_out, b_out, tev, tl, rl, flag, tl_seen, rl_seen;
	logic [7:0] lv, addr;
	logic [7:0] cnt[4] = '{8'h3C, 8'hA5, 8'h5A, 8'hC3};
	logic [31:0] wd, rdata, v;
	int miscompares = 0;
	int compares = 0;
	taix_top uut (
		.MCLK(mclk), .RST_N(rst_n), .INSTR_VALID(vld), .INSTR_CODE(code),
		.ACC_IN(acc), .UPPER_IN(upper), .TIMER1_COUNT(cnt[0]),
		.TIMER2_COUNT(cnt[1]), .TIMER3_COUNT(cnt[2]), .TIMER4_COUNT(cnt[3]),
		.TIMER_EVENT(tev), .ACC_LOAD(a_ld), .ACC_OUT(a_out),
		.UPPER_LOAD(b_ld), .UPPER_OUT(b_out), .TIMER_LOAD(tl),
		.RELOAD_LOAD(rl), .LOAD_VALUE(lv), .SKIP_NEXT(skip),
		.EVENT_FLAG(flag), .IRQ(irq), .AVS_ADDRESS(addr), .AVS_READ(rd),
		.AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(4'hF),
		.AVS_READDATA(rdata), .AVS_WAITREQUEST(wq)
	);
	taix_seq sq (
		.clk(mclk), .rst_n(rst_n), .skip(skip), .a_ld(a_ld), .a_in(a_out),
		.b_ld(b_ld), .b_in(b_out), .valid(vld), .code(code), .acc_q(acc),
		.upper_q(upper)
	);
	// ----------------------------------------
	// clock, capture, helpers
	// ----------------------------------------
	initial
	begin
		forever #2 mclk = ~mclk;
	end
	// load strobes last one cycle, so latch them for later compares
	always @(posedge mclk)
	begin
		if (|tl)
			tl_seen <= tl;
		if (|rl)
			rl_seen <= rl;
	end
	task check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		rd <= !w;
		wr <= w;
		addr <= a;
		wd <= d;
		@(posedge mclk);
		while (wq !== 1'h0)
			@(posedge mclk);
		v = rdata;
		rd <= 1'h0;
		wr <= 1'h0;
	endtask : bus
	task exec(input logic [9:0] c, input logic [9:0] c2);
		tl_seen = 4'h0;
		rl_seen = 4'h0;
		sq.prog.push_back(c);
		if (c2 != 10'h000)
			sq.prog.push_back(c2);
		repeat (8) @(posedge mclk);
	endtask : exec
	task conclude;
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : conclude
	initial
	begin
		repeat (5000) @(posedge mclk);
		miscompares++;
		conclude();
	end
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial
	begin
		tev = 4'h0;
		rd = 1'h0;
		wr = 1'h0;
		addr = 8'h00;
		wd = 32'h0;
		repeat (16) @(posedge mclk);
		rst_n <= 1'h1;
		repeat (2) @(posedge mclk);
		bus(1'h0, 8'h00, 32'h0);
		check(v, 32'h1);
		for (int i = 0; i < 4; i++)
		begin
			exec(10'h270 + 10'(i), 10'h000);
			check({b_out, a_out}, cnt[i]);
			check({sq.upper_q, sq.acc_q}, cnt[i]);
			exec(10'h230 + 10'(i), 10'h000);
			check(tl_seen, 4'h1 << i);
			check(rl_seen, 4'h1 << i);
			check(lv, cnt[i]);
		end
		exec(10'h271, 10'h23F);
		check({tl_seen, rl_seen}, 8'h01);
		check(lv, cnt[1]);
		exec(10'h273, 10'h23B);
		check({tl_seen, rl_seen}, 8'h04);
		check(lv, cnt[3]);
		$display("test reads and writes done");
		for (int i = 0; i < 4; i++)
		begin
			tev <= 4'h1 << i;
			@(posedge mclk);
			tev <= 4'h0;
			exec(10'h270, 10'h000);
			check(flag, 4'h1 << i);
			exec(10'h280 + 10'(i), 10'h272);
			check({sq.upper_q, sq.acc_q}, cnt[0]);
			check(flag, 4'h0);
			check(sq.skipped, i + 1);
			exec(10'h280 + 10'(i), 10'h272);
			check({sq.upper_q, sq.acc_q}, cnt[2]);
			check(sq.skipped, i + 1);
		end
		$display("test skips done");
		bus(1'h0, 8'h08, 32'h0);
		check(v, 32'h1F);
		check(irq, 1'h0);
		bus(1'h1, 8'h0C, 32'h10);
		bus(1'h0, 8'h0C, 32'h0);
		check(v, 32'h10);
		check(irq, 1'h1);
		bus(1'h1, 8'h08, 32'h10);
		bus(1'h0, 8'h08, 32'h0);
		check(v, 32'h0F);
		check(irq, 1'h0);
		bus(1'h0, 8'h04, 32'h0);
		check(v, 32'h00027200);
		bus(1'h1, 8'h40, 32'hFFFFFFFF);
		bus(1'h0, 8'h40, 32'h0);
		check(v, 32'h0);
		$display("test registers done");
		// disabled: group opcodes must leave A, B and the strobes alone
		bus(1'h1, 8'h00, 32'h0);
		bus(1'h0, 8'h00, 32'h0);
		check(v, 32'h0);
		exec(10'h271, 10'h23F);
		check({sq.upper_q, sq.acc_q}, cnt[2]);
		check(rl_seen, 4'h0);
		bus(1'h0, 8'h10, 32'h0);
		check(v, 32'h1C);
		$display("test enable done");
		conclude();
	end
endmodule : testbench
